// ==== hdl/bru_consts.svh ====
// constants for the branch instruction unit: opcodes, field positions, pc advances, reset values
`ifndef BRU_CONSTS_SVH
`define BRU_CONSTS_SVH
`define BRU_OP_RETURN_INT   8'h32
`define BRU_OP_LONG_JUMP    8'h02
`define BRU_OP_SHORT_JUMP   8'h80
`define BRU_OP_INDEXED_JUMP 8'h73
`define BRU_OP_COMPARE_JUMP_NOT_EQUAL_DIRECT  8'hb5
`define BRU_OP_COMPARE_JUMP_NOT_EQUAL_ACC_IMM 8'hb4
`define BRU_OP_JUMP_ACC_Z   8'h60
`define BRU_OP_JUMP_ACC_NZ  8'h70
`define BRU_OP_DECREMENT_JUMP_NONZERO_DIRECT  8'hd5
`define BRU_ABSOLUTE_PAGE_JUMP_LOW5       5'h01
`define BRU_COMPARE_JUMP_NOT_EQUAL_IND_HI7    7'h5b
`define BRU_COMPARE_JUMP_NOT_EQUAL_REG_HI5    5'h17
`define BRU_DECREMENT_JUMP_NONZERO_REG_HI5    5'h1b
`define BRU_PAGE_BITS       11
`define BRU_ADV_TWO         16'h0002
`define BRU_ADV_THREE       16'h0003
`define BRU_ADV_ONE         16'h0001
`define BRU_PC_RESET        16'h0000
`define BRU_SP_RESET        8'h07
`endif

// ==== hdl/bru_core.sv ====
// branch instruction unit: decode and execute of control transfer instructions
// Operation
// - long_jump loads full sixteen-bit target
// - absolute_page_jump replaces low eleven pc bits
// - compare accumulator immediate, branch if different
// - compare indirect byte via working register
// - compares set carry when first is less
// - decrement working register, branch if nonzero
// - relative branches: advance two (three for three-byte forms), add offset
`timescale 1ns/1ns
`include "bru_consts.svh"
module bru_core
	import bru_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// instruction start
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	output logic             busy,
	output logic             done,
	// program memory
	output logic             code_req,
	output logic      [15:0] code_addr,
	input  wire logic        code_valid,
	input  wire logic [7:0]  code_data,
	// internal data memory
	output logic             data_rd,
	output logic             data_wr,
	output logic      [7:0]  data_addr,
	output logic      [7:0]  data_wdata,
	input  wire logic        data_valid,
	input  wire logic [7:0]  data_rdata,
	// core state
	input  wire logic [7:0]  acc,
	input  wire logic [15:0] data_pointer,
	input  wire logic [1:0]  reg_bank,
	output logic      [15:0] pc,
	output logic      [7:0]  sp,
	output logic             carry,
	output logic             carry_we,
	output logic             int_level_release,
	output logic             unknown_op
);
	bru_state_e  state, next_state;
	logic [7:0]  op, next_op;
	logic [7:0]  byte1, next_byte1;
	logic [7:0]  byte2, next_byte2;
	logic [7:0]  mem, next_mem;
	logic [15:0] next_pc;
	logic [7:0]  next_sp;
	logic        next_carry, next_carry_we, next_done, next_release, next_unknown;
	logic        next_code_req, next_data_rd, next_data_wr;
	logic [15:0] next_code_addr;
	logic [7:0]  next_data_addr, next_data_wdata;
	logic [7:0]  cmp_lhs, cmp_rhs, rel_off, dec_val;
	logic [15:0] rel_target;
	logic        ne, lt;
	logic [1:0]  len;
	logic        needs_mem;

	wire is_absolute_page_jump    = (op[4:0] == `BRU_ABSOLUTE_PAGE_JUMP_LOW5);
	wire is_compare_jump_not_equal_in = (op[7:1] == `BRU_COMPARE_JUMP_NOT_EQUAL_IND_HI7);
	wire is_compare_jump_not_equal_rg = (op[7:3] == `BRU_COMPARE_JUMP_NOT_EQUAL_REG_HI5);
	wire is_decrement_jump_nonzero_rg = (op[7:3] == `BRU_DECREMENT_JUMP_NONZERO_REG_HI5);
	wire is_compare_jump_not_equal    = is_compare_jump_not_equal_in || is_compare_jump_not_equal_rg || op == `BRU_OP_COMPARE_JUMP_NOT_EQUAL_ACC_IMM || op == `BRU_OP_COMPARE_JUMP_NOT_EQUAL_DIRECT;
	wire is_decrement_jump_nonzero    = is_decrement_jump_nonzero_rg || op == `BRU_OP_DECREMENT_JUMP_NONZERO_DIRECT;
	wire three_byte = is_compare_jump_not_equal || op == `BRU_OP_LONG_JUMP || op == `BRU_OP_DECREMENT_JUMP_NONZERO_DIRECT;
	wire [7:0] bank_base = {3'h0, reg_bank, 3'h0};

	// offset comes from the last operand byte
	assign rel_off = three_byte ? byte2 : byte1;
	assign cmp_lhs = (is_compare_jump_not_equal_in || is_compare_jump_not_equal_rg) ? mem : acc;
	assign cmp_rhs = (op == `BRU_OP_COMPARE_JUMP_NOT_EQUAL_DIRECT) ? mem : byte1;
	assign dec_val = mem - 8'h01;

	bru_target u_target (
		.pc         (pc),
		.offset     (rel_off),
		.lhs        (cmp_lhs),
		.rhs        (cmp_rhs),
		.rel_target (rel_target),
		.not_equal  (ne),
		.less_than  (lt)
	);

	always_comb begin
		len = 2'd0;
		if (opcode == `BRU_OP_RETURN_INT || opcode == `BRU_OP_INDEXED_JUMP)
			len = 2'd0;
		else if (opcode == `BRU_OP_LONG_JUMP || opcode == `BRU_OP_COMPARE_JUMP_NOT_EQUAL_ACC_IMM || opcode == `BRU_OP_COMPARE_JUMP_NOT_EQUAL_DIRECT
			|| opcode[7:1] == `BRU_COMPARE_JUMP_NOT_EQUAL_IND_HI7 || opcode[7:3] == `BRU_COMPARE_JUMP_NOT_EQUAL_REG_HI5
			|| opcode == `BRU_OP_DECREMENT_JUMP_NONZERO_DIRECT)
			len = 2'd2;
		else
			len = 2'd1;
	end

	// which instructions read a data byte before executing
	assign needs_mem = is_compare_jump_not_equal_in || is_compare_jump_not_equal_rg || is_decrement_jump_nonzero || op == `BRU_OP_COMPARE_JUMP_NOT_EQUAL_DIRECT;

	always_comb begin
		next_state      = state;
		next_op         = op;
		next_byte1      = byte1;
		next_byte2      = byte2;
		next_mem        = mem;
		next_pc         = pc;
		next_sp         = sp;
		next_carry      = carry;
		next_carry_we   = 1'b0;
		next_done       = 1'b0;
		next_release    = 1'b0;
		next_unknown    = 1'b0;
		next_code_req   = 1'b0;
		next_code_addr  = code_addr;
		next_data_rd    = 1'b0;
		next_data_wr    = 1'b0;
		next_data_addr  = data_addr;
		next_data_wdata = data_wdata;
		case (state)
			BRU_IDLE: begin
				if (start) begin
					next_op = opcode;
					// pc points at the opcode; operand bytes follow it
					if (opcode == `BRU_OP_RETURN_INT) begin
						next_data_rd   = 1'b1;
						next_data_addr = sp;
						next_state     = BRU_POP_HI;
					end else if (opcode == `BRU_OP_INDEXED_JUMP) begin
						next_state = BRU_EXEC;
					end else if (opcode[4:0] == `BRU_ABSOLUTE_PAGE_JUMP_LOW5 || len != 2'd1 || opcode == `BRU_OP_SHORT_JUMP
						|| opcode == `BRU_OP_JUMP_ACC_Z || opcode == `BRU_OP_JUMP_ACC_NZ
						|| opcode[7:3] == `BRU_DECREMENT_JUMP_NONZERO_REG_HI5) begin
						next_code_req  = 1'b1;
						next_code_addr = pc + `BRU_ADV_ONE;
						next_state     = BRU_FETCH1;
					end else begin
						// not a control transfer: flag it and step past the opcode
						next_unknown = 1'b1;
						next_done    = 1'b1;
						next_pc      = pc + `BRU_ADV_ONE;
					end
				end
			end
			BRU_FETCH1: begin
				next_code_req = 1'b1;
				if (code_valid) begin
					next_byte1 = code_data;
					if (three_byte) begin
						next_code_addr = code_addr + `BRU_ADV_ONE;
						next_state     = BRU_FETCH2;
					end else begin
						next_code_req = 1'b0;
						next_state    = needs_mem ? BRU_MEM_RD : BRU_EXEC;
						next_data_rd  = needs_mem;
						next_data_addr = bank_base | {5'h00, op[2:0]};
					end
				end
			end
			BRU_FETCH2: begin
				next_code_req = 1'b1;
				if (code_valid) begin
					next_byte2    = code_data;
					next_code_req = 1'b0;
					next_data_rd  = needs_mem;
					if (is_compare_jump_not_equal_in || is_compare_jump_not_equal_rg)
						next_data_addr = bank_base | {5'h00, op[2:0] & (is_compare_jump_not_equal_in ? 3'h1 : 3'h7)};
					else
						next_data_addr = byte1;
					next_state = needs_mem ? BRU_MEM_RD : BRU_EXEC;
				end
			end
			BRU_MEM_RD: begin
				next_data_rd = 1'b1;
				if (data_valid) begin
					next_data_rd = 1'b0;
					if (is_compare_jump_not_equal_in && mem == 8'h00 && data_addr[7:3] == bank_base[7:3]) begin
						// first read gave the pointer; now read the byte it addresses
						next_mem       = 8'h01;
						next_data_addr = data_rdata;
						next_data_rd   = 1'b1;
					end else begin
						next_mem   = data_rdata;
						next_state = BRU_EXEC;
					end
				end
			end
			BRU_EXEC: begin
				next_done  = 1'b1;
				next_state = BRU_IDLE;
				next_mem   = 8'h00;
				if (op == `BRU_OP_LONG_JUMP) begin
					next_pc = {byte1, byte2};
				end else if (is_absolute_page_jump) begin
					next_pc = pc + `BRU_ADV_TWO;
					next_pc = {next_pc[15:`BRU_PAGE_BITS], op[7:5], byte1};
				end else if (op == `BRU_OP_INDEXED_JUMP) begin
					next_pc = {8'h00, acc} + data_pointer;
				end else if (is_compare_jump_not_equal) begin
					next_pc = ne ? rel_target + `BRU_ADV_THREE : pc + `BRU_ADV_THREE;
					next_carry    = lt;
					next_carry_we = 1'b1;
				end else if (is_decrement_jump_nonzero) begin
					next_data_wr    = 1'b1;
					next_data_wdata = dec_val;
					if (is_decrement_jump_nonzero_rg)
						next_pc = (dec_val != 8'h00) ? rel_target + `BRU_ADV_TWO : pc + `BRU_ADV_TWO;
					else
						next_pc = (dec_val != 8'h00) ? rel_target + `BRU_ADV_THREE : pc + `BRU_ADV_THREE;
				end else begin
					if (op == `BRU_OP_SHORT_JUMP || (op == `BRU_OP_JUMP_ACC_Z && acc == 8'h00)
						|| (op == `BRU_OP_JUMP_ACC_NZ && acc != 8'h00))
						next_pc = rel_target + `BRU_ADV_TWO;
					else
						next_pc = pc + `BRU_ADV_TWO;
				end
			end
			BRU_POP_HI: begin
				next_data_rd = 1'b1;
				if (data_valid) begin
					next_pc[15:8]  = data_rdata;
					next_sp        = sp - 8'h01;
					next_data_addr = sp - 8'h01;
					next_state     = BRU_POP_LO;
				end
			end
			BRU_POP_LO: begin
				next_data_rd = 1'b1;
				if (data_valid) begin
					next_data_rd  = 1'b0;
					next_pc[7:0]  = data_rdata;
					next_sp       = sp - 8'h01;
					next_state    = BRU_DONE;
				end
			end
			default: begin
				next_release = 1'b1;
				next_done    = 1'b1;
				next_state   = BRU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state             <= BRU_IDLE;
			op                <= 8'h00;
			byte1             <= 8'h00;
			byte2             <= 8'h00;
			mem               <= 8'h00;
			pc                <= `BRU_PC_RESET;
			sp                <= `BRU_SP_RESET;
			carry             <= 1'b0;
			carry_we          <= 1'b0;
			done              <= 1'b0;
			int_level_release <= 1'b0;
			unknown_op        <= 1'b0;
			code_req          <= 1'b0;
			code_addr         <= 16'h0000;
			data_rd           <= 1'b0;
			data_wr           <= 1'b0;
			data_addr         <= 8'h00;
			data_wdata        <= 8'h00;
		end else begin
			state             <= next_state;
			op                <= next_op;
			byte1             <= next_byte1;
			byte2             <= next_byte2;
			mem               <= next_mem;
			pc                <= next_pc;
			sp                <= next_sp;
			carry             <= next_carry;
			carry_we          <= next_carry_we;
			done              <= next_done;
			int_level_release <= next_release;
			unknown_op        <= next_unknown;
			code_req          <= next_code_req;
			code_addr         <= next_code_addr;
			data_rd           <= next_data_rd;
			data_wr           <= next_data_wr;
			data_addr         <= next_data_addr;
			data_wdata        <= next_data_wdata;
		end
	end

	assign busy = (state != BRU_IDLE);
endmodule : bru_core

// ==== hdl/bru_pkg.sv ====
// types shared by the branch instruction unit
package bru_pkg;
	typedef enum logic [1:0] {
		BRU_CMP_NONE,
		BRU_CMP_ACC,
		BRU_CMP_MEM
	} bru_cmp_e;
	typedef enum logic [3:0] {
		BRU_IDLE,
		BRU_FETCH1,
		BRU_FETCH2,
		BRU_MEM_RD,
		BRU_EXEC,
		BRU_POP_HI,
		BRU_POP_LO,
		BRU_DONE
	} bru_state_e;
endpackage : bru_pkg

// ==== hdl/bru_target.sv ====
// branch target and compare arithmetic
`timescale 1ns/1ns
`include "bru_consts.svh"
module bru_target
	import bru_pkg::*;
(
	// program counter and operands
	input  wire logic [15:0] pc,
	input  wire logic [7:0]  offset,
	input  wire logic [7:0]  lhs,
	input  wire logic [7:0]  rhs,
	// results
	output logic      [15:0] rel_target,
	output logic             not_equal,
	output logic             less_than
);
	// offset is two's complement, sign extended to sixteen bits
	assign rel_target = pc + {{8{offset[7]}}, offset};
	assign not_equal  = (lhs != rhs);
	// unsigned compare: carry set when first operand below second
	assign less_than  = (lhs < rhs);
endmodule : bru_target

// ==== tb/bru_code_mem.sv ====
// program memory model answering operand fetches with random stalls
`timescale 1ns/1ns
module bru_code_mem (
	// clock
	input  wire logic        clock,
	// fetch port
	input  wire logic        code_req,
	input  wire logic [15:0] code_addr,
	output logic             code_valid,
	output logic      [7:0]  code_data
);
	logic [7:0] mem [0:65535];
	logic [7:0] lfsr = 8'h5b;
	always_ff @(posedge clock) begin
		lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
	end
	// stalls on some cycles so the wait path of the unit is exercised
	assign code_valid = code_req && lfsr[0];
	// lines keep moving while not answering, so a stale sample shows
	assign code_data  = code_valid ? mem[code_addr] : lfsr;
endmodule : bru_code_mem

// ==== tb/bru_core_asserts.sv ====
// port assertions for the branch unit
`timescale 1ns/1ns
`include "bru_consts.svh"
module bru_core_asserts
	import bru_pkg::*;
(
	// watched ports
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        start,
	input wire logic [7:0]  opcode,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        code_req,
	input wire logic        code_valid,
	input wire logic [7:0]  code_data,
	input wire logic [7:0]  acc,
	input wire logic [15:0] pc,
	input wire logic [7:0]  sp,
	input wire logic        carry,
	input wire logic        carry_we,
	input wire logic        data_wr,
	input wire logic        int_level_release
);
	logic [15:0] pc0;
	logic [7:0]  op0, sp0, b1, b2;
	logic        got1;
	wire  [15:0] s1 = {{8{b1[7]}}, b1};
	wire  [15:0] s2 = {{8{b2[7]}}, b2};
	wire  [15:0] pc2 = pc0 + 16'h0002;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{pc0, op0, sp0, b1, b2, got1} <= '0;
		end else if (start && !busy) begin
			{pc0, op0, sp0, got1} <= {pc, opcode, sp, 1'b0};
		end else if (code_req && code_valid) begin
			got1 <= 1'b1;
			b1   <= got1 ? b1 : code_data;
			b2   <= got1 ? code_data : b2;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence fin(logic [7:0] o);
		done && op0 == o;
	endsequence
	chk_long_target: assert property (fin(`BRU_OP_LONG_JUMP) |-> pc == {b1, b2})
		else $error("long jump target wrong");
	chk_page_target: assert property (done && op0[4:0] == `BRU_ABSOLUTE_PAGE_JUMP_LOW5 |-> pc == {pc2[15:11], op0[7:5], b1})
		else $error("page jump target wrong");
	chk_short_target: assert property (fin(`BRU_OP_SHORT_JUMP) |-> pc == pc2 + s1)
		else $error("short jump target wrong");
	chk_zero_branch: assert property (fin(`BRU_OP_JUMP_ACC_Z) |-> pc == pc2 + (acc == 8'h00 ? s1 : 16'h0000))
		else $error("zero branch target wrong");
	chk_cmp_branch: assert property (fin(`BRU_OP_COMPARE_JUMP_NOT_EQUAL_ACC_IMM) |-> pc == pc0 + 16'h0003 + (acc != b1 ? s2 : 16'h0000))
		else $error("compare branch target wrong");
	chk_cmp_carry: assert property (fin(`BRU_OP_COMPARE_JUMP_NOT_EQUAL_ACC_IMM) |-> carry_we && carry == (acc < b1))
		else $error("compare carry wrong");
	chk_carry_done: assert property (carry_we |-> done && !$past(done))
		else $error("carry write outside finish");
	chk_interrupt_return_stack: assert property (fin(`BRU_OP_RETURN_INT) |-> sp == sp0 - 8'h02 && int_level_release)
		else $error("interrupt return stack wrong");
	chk_dec_write: assert property (data_wr |-> done && op0[7:4] == 4'hd)
		else $error("decrement write misplaced");
endmodule : bru_core_asserts
bind bru_core bru_core_asserts i_chk (.clock(clock), .arst_n(arst_n), .start(start), .opcode(opcode), .busy(busy),
	.done(done), .code_req(code_req), .code_valid(code_valid), .code_data(code_data), .acc(acc), .pc(pc), .sp(sp),
	.carry(carry), .carry_we(carry_we), .data_wr(data_wr), .int_level_release(int_level_release));

// ==== tb/testbench.sv ====
// self-checking bench for the branch unit
`timescale 1ns/1ns
`include "bru_consts.svh"
module testbench;
	logic        clock = 1'b0, arst_n = 1'b0, start = 1'b0, cx = 1'b0;
	logic [7:0]  opcode = 8'h00, acc = 8'h00, cnt = 8'h00;
	logic [15:0] data_pointer = 16'h0000, pcx = `BRU_PC_RESET;
	logic [1:0]  reg_bank = 2'h0;
	logic        busy, done, code_req, code_valid, data_rd, data_wr, data_valid, carry, carry_we, ilr, unk;
	logic [15:0] code_addr, pc;
	logic [7:0]  code_data, data_addr, data_wdata, data_rdata, sp, spx = `BRU_SP_RESET;
	logic [7:0]  dmem [0:255];
	logic [7:0]  ops [14] = '{8'h02, 8'h01, 8'h80, 8'h60, 8'h70, 8'hb4, 8'hb5, 8'hb6, 8'hb8, 8'hd5, 8'hd8, 8'h73, 8'h32,
		8'h00};
	logic [31:0] rs = 32'd17347;
	int          n_fail = 0, cmp_count = 0;
	always #25 clock = ~clock;
	bru_core i_bru_core (.clock(clock), .arst_n(arst_n), .start(start), .opcode(opcode), .busy(busy), .done(done),
		.code_req(code_req), .code_addr(code_addr), .code_valid(code_valid), .code_data(code_data),
		.data_rd(data_rd), .data_wr(data_wr), .data_addr(data_addr), .data_wdata(data_wdata),
		.data_valid(data_valid), .data_rdata(data_rdata), .acc(acc), .data_pointer(data_pointer),
		.reg_bank(reg_bank), .pc(pc), .sp(sp), .carry(carry), .carry_we(carry_we),
		.int_level_release(ilr), .unknown_op(unk));
	bru_code_mem i_bru_code_mem (.clock(clock), .code_req(code_req), .code_addr(code_addr),
		.code_valid(code_valid), .code_data(code_data));
	assign data_valid = data_rd;
	// idle data lines keep moving so a stale read cannot pass
	assign data_rdata = data_rd ? dmem[data_addr] : cnt;
	always @(posedge clock) begin
		cnt <= cnt + 8'h01;
		if (data_wr)
			dmem[data_addr] <= data_wdata;
	end
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd
	function automatic logic [15:0] rel(input logic [15:0] base, input logic [7:0] off, input logic take);
		return base + (take ? {{8{off[7]}}, off} : 16'h0000);
	endfunction : rel
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done
	task automatic run(input logic [7:0] op);
		logic [7:0]  b1, b2, ra, v, w;
		logic [15:0] epc;
		logic        ec;
		int          i;
		v = 8'(rnd());
		b1 = 8'(rnd());
		b2 = 8'(rnd());
		// offsets at both ends of the signed range now and then
		if (v[5])
			b1 = {b1[7], {7{~b1[7]}}};
		op[7:5] = op == 8'h01 ? v[7:5] : op[7:5];
		op[2:0] = (op == 8'hd8 || op == 8'hb8) ? v[2:0] : (op == 8'hb6 ? {2'h3, v[0]} : op[2:0]);
		reg_bank = 2'(rnd());
		acc = v[1] ? b1 : (v[2] ? 8'h00 : 8'(rnd()));
		data_pointer = 16'(rnd());
		// direct forms address the byte named by the first operand; indirect ones use r0 or r1
		if (op == 8'hb5 || op == 8'hd5)
			ra = b1;
		else
			ra = {3'h0, reg_bank, (op[7:1] == 7'h5b) ? {2'h0, op[0]} : op[2:0]};
		dmem[ra] = v[3] ? 8'h01 : (v[1] ? b1 : 8'(rnd()));
		w = dmem[ra];
		// a pointer aimed at its own register must not be overwritten
		if (v[4] && w != ra)
			dmem[w] = b1;
		i_bru_code_mem.mem[pcx + 16'h0001] = b1;
		i_bru_code_mem.mem[pcx + 16'h0002] = b2;
		// carry holds unless a compare writes it
		ec = cx;
		casez (op)
			8'h02: epc = {b1, b2};
			8'b???00001: epc = {pcx[15:11] + 5'((pcx[10:0] + 11'h002) < 11'h002), op[7:5], b1};
			8'h80: epc = rel(pcx + 16'h0002, b1, 1'b1);
			8'h60: epc = rel(pcx + 16'h0002, b1, acc == 8'h00);
			8'h70: epc = rel(pcx + 16'h0002, b1, acc != 8'h00);
			8'hb4: {epc, ec} = {rel(pcx + 16'h0003, b2, acc != b1), acc < b1};
			8'b1011011?: {epc, ec} = {rel(pcx + 16'h0003, b2, dmem[w] != b1), dmem[w] < b1};
			8'hb5: {epc, ec} = {rel(pcx + 16'h0003, b2, acc != w), acc < w};
			8'b10111???: {epc, ec} = {rel(pcx + 16'h0003, b2, w != b1), w < b1};
			8'b11011???: epc = rel(pcx + 16'h0002, b1, w != 8'h01);
			8'hd5: epc = rel(pcx + 16'h0003, b2, w != 8'h01);
			8'h73: epc = 16'(acc) + data_pointer;
			8'h32: epc = {dmem[spx], dmem[spx - 8'h01]};
			default: epc = pcx + 16'h0001;
		endcase
		spx = op == 8'h32 ? spx - 8'h02 : spx;
		opcode = op;
		start = 1'b1;
		@(posedge clock);
		#2 start = 1'b0;
		check("busy", 16'(busy), 16'(op != 8'h00));
		for (i = 0; i < 80 && done !== 1'b1; i++) begin
			@(posedge clock);
			#2;
		end
		if (i == 80) begin
			n_fail++;
			test_done();
		end
		check("pc", pc, epc);
		check("carry", 16'({carry_we, carry}), 16'({op[7:4] == 4'hb, ec}));
		check("sp", 16'(sp), 16'(spx));
		check("release", 16'(ilr), 16'(op == 8'h32));
		check("unknown", 16'(unk), 16'(op == 8'h00));
		check("idle", 16'(busy), 16'h0000);
		@(posedge clock);
		#2;
		if (op[7:3] == 5'h1b || op == 8'hd5)
			check("reg", 16'(dmem[ra]), 16'(w - 8'h01));
		pcx = epc;
		cx = ec;
	endtask : run
	initial begin
		for (int k = 0; k < 256; k++)
			dmem[k] = 8'(rnd());
		repeat (12) @(posedge clock);
		#2 arst_n = 1'b1;
		check("pc reset", pc, `BRU_PC_RESET);
		check("sp reset", 16'(sp), 16'(`BRU_SP_RESET));
		repeat (300) run(ops[rnd() % 14]);
		// reset in mid-run: the unit and the bench's expected pc, sp and carry return to their reset values
		arst_n = 1'b0;
		repeat (2) @(posedge clock);
		#2;
		check("pc reset", pc, `BRU_PC_RESET);
		check("sp reset", 16'(sp), 16'(`BRU_SP_RESET));
		check("carry reset", 16'({carry_we, carry}), 16'h0000);
		arst_n = 1'b1;
		pcx = `BRU_PC_RESET;
		spx = `BRU_SP_RESET;
		cx = 1'b0;
		repeat (300) run(ops[rnd() % 14]);
		test_done();
	end
endmodule : testbench
